// ---- rtl/measurement_scan_control.v ----
// What this block does
// - Amend bit set: scaled ADC result moved into IIR accumulator at sequence end.
// - In balancing modes the amend bit is ignored and treated as one.
// - Readback bit picks unfiltered or IIR data for cell and block registers.
// - Readback bit latched at scan request; steers sum, min, max, spread, alerts.
// - Scan-type field bits 8:6 selects one of eight scan kinds.
// - Comparator scans force unipolar and skip bipolar-configured cells.
// - Calibration scan updates correction coefficients and measures nothing else.
// - In balancing modes the scan-type field is ignored; ADC-only scan runs.
// - Oversampling field bits 5:3 gives 1,4,8,16,32,64 or 128 acquisitions.
// - Oversampling field is disregarded during calibration scans.
// - In balancing modes oversampling field is ignored; sixteen times applies.
// - Path bit routes cells via primary mux at zero, alternate at one.
// - A switch diagnostic scan type overrides the path bit.
// - Sweep bit zero selects pyramid (default), one selects ramp.
// - Ramp ignored for comparator and calibration scans; balancing uses pyramid.
// - Scan-request bit is a self-clearing strobe and reads as zero.
// - Writing request one starts a sequence and a result transfer.
// - Writing request zero does a transfer or setup without a sequence.
// - Request while busy or complete stores bits 12:1, rejects, raises alert.
// - A write without request can clear complete, timeout and ready flags.
// - Complete flag set when acquisition ends; requests rejected while it is high.
// - Ready flag set once all results moved together to data registers.
// - Complete, timeout, ready clear only on written zero; writing one does nothing.
`timescale 1ns/1ps
`include "scan_ctrl_defines.vh"

module measurement_scan_control (
    input wire clk_i,
    input wire rst_i,
    // Classic Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Balancing-mode indication from the balancing engine (asynchronous)
    input wire auto_balance_i,
    // Engine events, same clock domain, one-cycle pulses
    input wire acq_done_i,
    input wire acq_timeout_i,
    input wire results_moved_i,
    // Sequencer controls
    output reg scan_start_o,
    output reg transfer_o,
    output reg setup_apply_o,
    output reg scan_busy_o,
    output reg [2:0] scan_type_o,
    output reg [7:0] sample_count_o,
    output reg iir_amend_o,
    output reg filtered_readback_o,
    output reg stats_filtered_o,
    output reg alt_path_o,
    output reg ramp_sweep_o,
    output reg unipolar_force_o,
    output reg skip_bipolar_o,
    output reg calibrate_o,
    output reg comparator_en_o,
    output reg adc_en_o,
    output reg request_rejected_alert_o
);

    // Software-held fields 12:1
    reg [15:0] ctrl_q;
    reg complete_q;
    reg timeout_q;
    reg ready_q;
    reg busy_q;
    reg bal_meta_q;
    reg bal_q;
    reg scan_bal_q;

    // Oversampling code to number of acquisitions
    function [7:0] ovs_count;
        input [2:0] code;
        begin
            case (code)
                3'h0: ovs_count = 8'h01;
                3'h1: ovs_count = 8'h04;
                3'h2: ovs_count = 8'h08;
                3'h3: ovs_count = 8'h10;
                3'h4: ovs_count = 8'h20;
                3'h5: ovs_count = 8'h40;
                default: ovs_count = 8'h80;
            endcase
        end
    endfunction

    // Scan type uses the comparator
    function uses_comp;
        input [2:0] t;
        begin
            uses_comp = (t == `SCAN_ADC_COMP) || (t == `SCAN_COMP);
        end
    endfunction

    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctrl_wr = bus_req & wb_we_i & (wb_adr_i == `ADDR_MEAS_CTRL);
    wire lo_wr = ctrl_wr & wb_sel_i[0];
    wire hi_wr = ctrl_wr & wb_sel_i[1];
    wire alert_wr = bus_req & wb_we_i & (wb_adr_i == `ADDR_ALERT) & wb_sel_i[0];
    wire req_wr = lo_wr & wb_dat_i[`BIT_REQUEST];
    wire reject = req_wr & (busy_q | complete_q);
    wire accept = req_wr & ~busy_q & ~complete_q;

    // Fields as they stand after this write
    wire [15:0] wmask = {{8{hi_wr}}, {8{lo_wr}}} & `STORE_MASK;
    wire [15:0] ctrl_d = (ctrl_q & ~wmask) | (wb_dat_i[15:0] & wmask);
    wire [2:0] type_d = ctrl_d[`SCAN_TYPE_HI:`SCAN_TYPE_LO];
    wire bal_now = bal_q;
    wire [2:0] eff_type = bal_now ? `SCAN_ADC : type_d;

    always @(posedge clk_i) begin
        if (rst_i) begin
            bal_meta_q <= 1'b0;
            bal_q <= 1'b0;
        end else begin
            bal_meta_q <= auto_balance_i;
            bal_q <= bal_meta_q;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `MEAS_CTRL_RESET;
            complete_q <= 1'b0;
            timeout_q <= 1'b0;
            ready_q <= 1'b0;
            busy_q <= 1'b0;
            scan_bal_q <= 1'b0;
            request_rejected_alert_o <= 1'b0;
        end else begin
            // bits 12:1 stored even on reject
            ctrl_q <= ctrl_d;
            // set wins over a written zero
            if (acq_done_i & busy_q)
                complete_q <= 1'b1;
            else if (hi_wr & ~wb_dat_i[`BIT_COMPLETE])
                complete_q <= 1'b0;
            if (acq_timeout_i & busy_q)
                timeout_q <= 1'b1;
            else if (hi_wr & ~wb_dat_i[`BIT_TIMEOUT])
                timeout_q <= 1'b0;
            if (results_moved_i)
                ready_q <= 1'b1;
            else if (hi_wr & ~wb_dat_i[`BIT_READY])
                ready_q <= 1'b0;
            if (accept) begin
                busy_q <= 1'b1;
                scan_bal_q <= bal_now;
            end else if ((acq_done_i | acq_timeout_i) & busy_q) begin
                busy_q <= 1'b0;
            end
            if (reject)
                request_rejected_alert_o <= 1'b1;
            else if (alert_wr & wb_dat_i[0])
                request_rejected_alert_o <= 1'b0;
        end
    end

    // Scan settings captured at the accepted request; strobes, readback select and amend pulse updated every cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            scan_start_o <= 1'b0;
            transfer_o <= 1'b0;
            setup_apply_o <= 1'b0;
            scan_type_o <= `SCAN_ADC;
            sample_count_o <= 8'h01;
            iir_amend_o <= 1'b0;
            filtered_readback_o <= 1'b0;
            stats_filtered_o <= 1'b0;
            alt_path_o <= 1'b0;
            ramp_sweep_o <= 1'b0;
            unipolar_force_o <= 1'b0;
            skip_bipolar_o <= 1'b0;
            calibrate_o <= 1'b0;
            comparator_en_o <= 1'b0;
            adc_en_o <= 1'b0;
        end else begin
            scan_start_o <= accept;
            transfer_o <= lo_wr;
            setup_apply_o <= lo_wr & ~wb_dat_i[`BIT_REQUEST];
            filtered_readback_o <= ctrl_d[`BIT_FILTERED_READBACK_SELECT];
            if (accept) begin
                scan_type_o <= eff_type;
                stats_filtered_o <= ctrl_d[`BIT_FILTERED_READBACK_SELECT];
                if (eff_type == `SCAN_CAL)
                    sample_count_o <= 8'h01;
                else if (bal_now)
                    sample_count_o <= ovs_count(`OVS_16X);
                else
                    sample_count_o <= ovs_count(ctrl_d[`OVS_HI:`OVS_LO]);
                if (eff_type == `SCAN_SW_SHORT || eff_type == `SCAN_SW_OPEN)
                    alt_path_o <= 1'b1;
                else
                    alt_path_o <= ctrl_d[`BIT_ALTPATH];
                // ramp only for plain ADC-class scans
                ramp_sweep_o <= ctrl_d[`BIT_SWEEP] & ~bal_now & ~uses_comp(eff_type)
                                & (eff_type != `SCAN_CAL);
                unipolar_force_o <= uses_comp(eff_type);
                skip_bipolar_o <= uses_comp(eff_type);
                calibrate_o <= (eff_type == `SCAN_CAL);
                comparator_en_o <= uses_comp(eff_type);
                adc_en_o <= (eff_type != `SCAN_COMP) && (eff_type != `SCAN_CAL);
            end
            iir_amend_o <= acq_done_i & busy_q & (scan_type_o != `SCAN_CAL)
                           & (scan_bal_q | ctrl_q[`BIT_AMEND]);
        end
    end

    always @(posedge clk_i) begin
        if (rst_i)
            scan_busy_o <= 1'b0;
        else
            scan_busy_o <= accept | (busy_q & ~(acq_done_i | acq_timeout_i));
    end

    // Bus answer one cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `ADDR_MEAS_CTRL: wb_dat_o <= {16'h0000, complete_q, timeout_q, ready_q,
                                                  ctrl_q[12:1], 1'b0};
                    `ADDR_ALERT: wb_dat_o <= {31'h0, request_rejected_alert_o};
                    `ADDR_ENGINE: wb_dat_o <= {29'h0, scan_bal_q, bal_q, busy_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // measurement_scan_control

// ---- rtl/scan_ctrl_defines.vh ----
`ifndef SCAN_CTRL_DEFINES_VH
`define SCAN_CTRL_DEFINES_VH

// Word addresses on the bus (byte address = index * 4)
`define ADDR_MEAS_CTRL 4'h0
`define ADDR_ALERT 4'h1
`define ADDR_ENGINE 4'h2

// Control register fields
`define BIT_COMPLETE 15
`define BIT_TIMEOUT 14
`define BIT_READY 13
`define BIT_AMEND 10
`define BIT_FILTERED_READBACK_SELECT 9
`define SCAN_TYPE_HI 8
`define SCAN_TYPE_LO 6
`define OVS_HI 5
`define OVS_LO 3
`define BIT_ALTPATH 2
`define BIT_SWEEP 1
`define BIT_REQUEST 0
`define MEAS_CTRL_RESET 16'h0000
// Bits 12:1 that software simply stores
`define STORE_MASK 16'h1FFE

// Scan types
`define SCAN_ADC 3'h0
`define SCAN_ADC_COMP 3'h1
`define SCAN_COMP 3'h2
`define SCAN_CAL 3'h3
`define SCAN_SW_SHORT 3'h4
`define SCAN_SW_OPEN 3'h5
`define SCAN_ODD_OPEN 3'h6
`define SCAN_EVEN_OPEN 3'h7

// Oversampling codes
`define OVS_16X 3'h3

`endif

// ---- tb/measurement_scan_control_checker.sv ----
`timescale 1ns/1ps
module measurement_scan_control_checker (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire auto_balance_i,
    input wire acq_done_i,
    input wire scan_start_o,
    input wire transfer_o,
    input wire setup_apply_o,
    input wire scan_busy_o,
    input wire [2:0] scan_type_o,
    input wire [7:0] sample_count_o,
    input wire filtered_readback_o,
    input wire ramp_sweep_o,
    input wire unipolar_force_o,
    input wire skip_bipolar_o,
    input wire calibrate_o,
    input wire comparator_en_o,
    input wire request_rejected_alert_o
);
    wire take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    wire ctrl_wr = take && wb_adr_i == 4'h0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_start_pulse: assert property (
        scan_start_o |-> wb_ack_o && scan_busy_o ##1 !scan_start_o) else $error("bad start");
    a_reject_busy: assert property (
        ctrl_wr && wb_sel_i[0] && wb_dat_i[0] && scan_busy_o |=> !scan_start_o
        && request_rejected_alert_o) else $error("busy request not rejected");
    a_alert_sticky: assert property (
        request_rejected_alert_o && !(take && wb_adr_i == 4'h1) |=> request_rejected_alert_o)
        else $error("alert lost");
    a_transfer_write: assert property (ctrl_wr && wb_sel_i[0] |=> transfer_o)
        else $error("control write gave no transfer");
    a_setup_only: assert property (setup_apply_o |-> !scan_start_o)
        else $error("setup write started scan");
    a_cal_single: assert property (
        calibrate_o |-> sample_count_o == 8'h01 && !ramp_sweep_o) else $error("bad cal setup");
    a_comp_unipolar: assert property (
        comparator_en_o |-> unipolar_force_o && skip_bipolar_o && !ramp_sweep_o)
        else $error("bad comparator setup");
    a_balance_fixed: assert property (
        auto_balance_i [*6] ##1 scan_start_o |-> scan_type_o == 3'h0
        && sample_count_o == 8'h10 && !ramp_sweep_o) else $error("bad balance setup");
    a_done_idle: assert property (scan_busy_o && acq_done_i |=> !scan_busy_o)
        else $error("busy after done");
    a_readback_store: assert property (
        ctrl_wr && wb_sel_i[1] |=> filtered_readback_o == $past(wb_dat_i[9]))
        else $error("readback select not stored");
    c_start: cover property (scan_start_o);
    c_reject: cover property (request_rejected_alert_o);
    c_cal: cover property (calibrate_o && scan_busy_o);
endmodule // measurement_scan_control_checker

bind measurement_scan_control measurement_scan_control_checker chk_u (.*);

// ---- tb/measurement_scan_control_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module measurement_scan_control_bench;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic auto_balance_i = 0, acq_done_i = 0, acq_timeout_i = 0, results_moved_i = 0;
    logic scan_start_o, transfer_o, setup_apply_o, scan_busy_o, iir_amend_o, adc_en_o;
    logic filtered_readback_o, stats_filtered_o, alt_path_o, ramp_sweep_o, unipolar_force_o;
    logic skip_bipolar_o, calibrate_o, comparator_en_o, request_rejected_alert_o;
    logic [2:0] scan_type_o;
    logic [7:0] sample_count_o;
    int fail_count = 0, tests_run = 0;
    measurement_scan_control dut_u (.*);
    initial forever #50 clk_i = ~clk_i;
    task automatic bus(input [3:0] a, input [15:0] d, input w = 1);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'h3, 16'h0, d};
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        q = wb_dat_o;
        @(posedge clk_i);
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task automatic done(input e);
        @(posedge clk_i) acq_done_i <= 1;
        @(posedge clk_i) acq_done_i <= 0;
        #1 `CHK(iir_amend_o, e)
        `CHK(scan_busy_o, 1'b0)
    endtask
    task automatic t_flags;
        bus(0, 16'h0, 0);
        `CHK(q, 32'h0)
        bus(0, 16'h0229);
        `CHK({scan_busy_o, filtered_readback_o, sample_count_o}, 10'h340)
        `CHK(stats_filtered_o, 1'b1)
        bus(0, 16'h0001);
        `CHK(request_rejected_alert_o, 1'b1)
        bus(0, 16'h0, 0);
        `CHK(q, 32'h0)
        @(posedge clk_i) {acq_timeout_i, results_moved_i} <= 2'b11;
        @(posedge clk_i) {acq_timeout_i, results_moved_i} <= 2'b00;
        bus(0, 16'hE000);
        bus(0, 16'h0, 0);
        `CHK(q[15:13], 3'b011)
        bus(0, 16'h0000);
        bus(0, 16'h0, 0);
        `CHK(q, 32'h0)
        `CHK(request_rejected_alert_o, 1'b1)
        bus(1, 16'h0001);
        bus(1, 16'h0, 0);
        `CHK({request_rejected_alert_o, q[0]}, 2'b00)
        bus(4'h7, 16'hFFFF);
        bus(4'h7, 16'h0, 0);
        `CHK(q, 32'h0)
    endtask
    task automatic t_types;
        logic [7:0] ovs [8] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h80};
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            d = {7'h0, i[2:0], i[2:0], 3'b010};
            bus(0, d);
            bus(0, d | 16'h1);
            `CHK(scan_type_o, i[2:0])
            `CHK(sample_count_o, i == 3 ? 8'h01 : ovs[i])
            `CHK(calibrate_o, i == 3)
            `CHK(adc_en_o, i != 2 && i != 3)
            `CHK(comparator_en_o, i == 1 || i == 2)
            `CHK(alt_path_o, i == 4 || i == 5)
            if (i < 4) `CHK(ramp_sweep_o, i == 0)
            done(0);
            bus(0, 16'h0);
        end
    endtask
    task automatic t_balance;
        bus(0, 16'h0401);
        done(1);
        bus(0, 16'h0001);
        `CHK(scan_start_o | scan_busy_o, 1'b0)
        bus(0, 16'h0);
        auto_balance_i <= 1;
        repeat (6) @(posedge clk_i);
        bus(0, 16'h0093);
        `CHK({scan_type_o, sample_count_o, ramp_sweep_o}, 12'h020)
        done(1);
        auto_balance_i <= 0;
    endtask
    task automatic tally_and_finish;
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        t_flags;
        t_types;
        t_balance;
        tally_and_finish;
    end
endmodule // measurement_scan_control_bench
